// ---- rifr_top.sv ----
// receiver event flags, fifo level flags and filtered signal strength readout
`timescale 1ns/1ns
module rifr_top
  import rifr_pkg::*;
#(
  parameter int FIFO_CNT_W = 6,
  parameter int FILT_SHIFT = 2
)
(
  input wire logic clock,
  input wire logic rst_n,
  // register port from the serial interface decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [rifr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // device context
  input wire logic [2:0] op_state,
  input wire logic [1:0] data_mode,
  input wire logic fsk_demod_sel,
  // event sources
  input wire logic sleep_timer_on,
  input wire logic sleep_timer_expire,
  input wire logic sleep_timeout_irq_enable,
  input wire logic rx_timer_on,
  input wire logic rx_timer_expire,
  input wire logic receive_timeout_irq_enable,
  input wire logic signal_valid_irq_enable,
  input wire logic [7:0] fsk_trigger_threshold,
  input wire logic preamble_pass,
  input wire logic preamble_pass_irq_enable,
  input wire logic syncword_pass,
  input wire logic syncword_pass_irq_enable,
  input wire logic node_match,
  input wire logic node_match_irq_enable,
  input wire logic checksum_pass,
  input wire logic checksum_pass_irq_enable,
  input wire logic packet_complete,
  input wire logic packet_complete_irq_enable,
  // fifo state
  input wire logic [FIFO_CNT_W-1:0] fifo_count,
  input wire logic fifo_full,
  input wire logic fifo_overflow,
  input wire logic [FIFO_CNT_W-1:0] fifo_threshold,
  // signal strength
  input wire logic [7:0] signal_strength_value_raw,
  input wire logic [7:0] squelch_threshold,
  output logic [7:0] event_flags,
  output logic buffer_flush,
  output logic packet_handler_reset,
  output logic [7:0] signal_strength_value
);
  import rifr_pkg::*;

  //----------------------------------------------------------------------------
  // combinational conditions
  //----------------------------------------------------------------------------
  rifr_state_s s_q;
  rifr_state_s s_d;
  logic packet_mode;
  logic fifo_modes;
  logic cmd_state_ok;
  logic [7:0] event_set;
  logic [7:0] event_clr;
  logic buffer_full_flag;
  logic buffer_not_empty_flag;
  logic buffer_threshold_flag;
  logic buffer_overflow_flag;
  logic [7:0] fifo_status;
  logic [7:0] filt_value;
  logic [7:0] strength_view;
  logic signed [12:0] filt_diff;
  logic signed [12:0] filt_step;
  logic [11:0] filt_target;

  assign packet_mode = (data_mode == MODE_PACKET);
  assign fifo_modes = (data_mode == MODE_BUFFER) || packet_mode;
  // clear and flush commands are dead outside these states
  assign cmd_state_ok = (op_state == OP_STBY) || (op_state == OP_TUNE) ||
                        (op_state == OP_RX) || (op_state == OP_EEPROM);

  always_comb
  begin
    event_set = 8'h00;
    event_set[BIT_SLEEP_TMO] = sleep_timer_on && sleep_timeout_irq_enable &&
                               sleep_timer_expire;
    event_set[BIT_RX_TMO] = rx_timer_on && receive_timeout_irq_enable &&
                            rx_timer_expire;
    event_set[BIT_SIG_VALID] = fsk_demod_sel && signal_valid_irq_enable &&
                               (signal_strength_value_raw > fsk_trigger_threshold);
    event_set[BIT_PREAMBLE] = preamble_pass && preamble_pass_irq_enable;
    event_set[BIT_SYNCWORD] = syncword_pass && syncword_pass_irq_enable;
    event_set[BIT_NODE] = packet_mode && node_match && node_match_irq_enable;
    event_set[BIT_CHECKSUM] = packet_mode && checksum_pass &&
                              checksum_pass_irq_enable;
    // completion is flagged whatever the checksum outcome
    event_set[BIT_PKT_DONE] = packet_mode && packet_complete &&
                              packet_complete_irq_enable;
  end

  // clear register maps one bit per flag; zero bits keep their flag
  assign event_clr = (reg_wr && (reg_addr == ADDR_EVENT_CLEAR) && cmd_state_ok) ?
                     reg_wdata : 8'h00;

  //----------------------------------------------------------------------------
  // fifo level flags
  //----------------------------------------------------------------------------
  // level flags, no storage: they fall the moment the condition goes away
  assign buffer_full_flag = fifo_modes && fifo_full;
  assign buffer_not_empty_flag = fifo_modes && (fifo_count != '0);
  assign buffer_threshold_flag = fifo_modes && (fifo_count >= fifo_threshold);
  assign buffer_overflow_flag = fifo_modes && fifo_overflow;

  always_comb
  begin
    fifo_status = 8'h00;
    fifo_status[BIT_FULL] = buffer_full_flag;
    fifo_status[BIT_NOT_EMPTY] = buffer_not_empty_flag;
    fifo_status[BIT_THRESH] = buffer_threshold_flag;
    fifo_status[BIT_OVERFLOW] = buffer_overflow_flag;
    // flush bit is write-only and reads as zero
    fifo_status[1:0] = s_q.fifo_resv;
  end

  //----------------------------------------------------------------------------
  // signal strength filter
  //----------------------------------------------------------------------------
  // first-order low-pass with FILT_FRAC fraction bits; a larger FILT_SHIFT
  // smooths more but responds slower to a real level change
  assign filt_target = {signal_strength_value_raw, {FILT_FRAC{1'b0}}};
  assign filt_diff = $signed({1'b0, filt_target}) - $signed({1'b0, s_q.filt_acc});
  assign filt_step = filt_diff >>> FILT_SHIFT;
  assign filt_value = s_q.filt_acc[11:FILT_FRAC];
  assign strength_view = (filt_value < squelch_threshold) ? 8'h00 : filt_value;

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // set wins over a clear arriving in the same cycle
    s_d.event_flags = (s_q.event_flags & ~event_clr) | event_set;
    if (reg_wr && (reg_addr == ADDR_FIFO_STATUS))
    begin
      s_d.fifo_resv = reg_wdata[1:0];
    end
    // filter only follows the indicator while receiving, else holds
    if (op_state == OP_RX)
    begin
      s_d.filt_acc = 12'(s_q.filt_acc + 12'(filt_step));
    end
    s_d.flush = 1'b0;
    s_d.ph_reset = 1'b0;
    if (op_state == OP_SLEEP)
    begin
      s_d.flush = 1'b1;
      s_d.ph_reset = 1'b1;
    end
    else if (reg_wr && (reg_addr == ADDR_FIFO_STATUS) && reg_wdata[BIT_FLUSH] &&
             cmd_state_ok)
    begin
      s_d.flush = 1'b1;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_EVENT_STATUS: s_d.rdata = s_q.event_flags;
        ADDR_FIFO_STATUS: s_d.rdata = fifo_status;
        ADDR_SIGNAL_STRENGTH: s_d.rdata = strength_view;
        default: s_d.rdata = RDATA_RESET;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q.event_flags <= EVENT_RESET;
      s_q.fifo_resv <= RESV_RESET;
      s_q.filt_acc <= FILT_RESET;
      s_q.rdata <= RDATA_RESET;
      s_q.flush <= 1'b0;
      s_q.ph_reset <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign event_flags = s_q.event_flags;
  assign buffer_flush = s_q.flush;
  assign packet_handler_reset = s_q.ph_reset;
  assign signal_strength_value = strength_view;

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_sleep_tmo_set: assert property (
    sleep_timer_on && sleep_timeout_irq_enable && sleep_timer_expire
    |=> event_flags[BIT_SLEEP_TMO])
    else $error("sleep timeout flag not set on expiry");

  a_rx_tmo_gate: assert property (
    !event_flags[BIT_RX_TMO] && !rx_timer_on
    |=> !event_flags[BIT_RX_TMO])
    else $error("receive timeout flag set with timer off");

  a_sig_valid_set: assert property (
    fsk_demod_sel && signal_valid_irq_enable && (signal_strength_value_raw > fsk_trigger_threshold)
    |=> event_flags[BIT_SIG_VALID])
    else $error("signal valid flag not set above trigger");

  a_node_pkt_only: assert property (
    !event_flags[BIT_NODE] && (data_mode != MODE_PACKET)
    |=> !event_flags[BIT_NODE])
    else $error("node match flag set outside packet mode");

  a_done_set_wins: assert property (
    packet_mode && packet_complete && packet_complete_irq_enable &&
    reg_wr && (reg_addr == ADDR_EVENT_CLEAR) && reg_wdata[BIT_PKT_DONE]
    |=> event_flags[BIT_PKT_DONE])
    else $error("packet complete event lost to clear");

  a_flag_clear: assert property (
    !event_set[BIT_PREAMBLE] && cmd_state_ok && reg_wr &&
    (reg_addr == ADDR_EVENT_CLEAR) && reg_wdata[BIT_PREAMBLE]
    |=> !event_flags[BIT_PREAMBLE])
    else $error("preamble flag not cleared by host");

  a_flag_sticky: assert property (
    event_flags[BIT_SYNCWORD] && !(reg_wr && (reg_addr == ADDR_EVENT_CLEAR))
    |=> event_flags[BIT_SYNCWORD])
    else $error("sync word flag dropped without clear");

  a_fifo_direct: assert property (
    reg_rd && (reg_addr == ADDR_FIFO_STATUS) && (data_mode == MODE_DIRECT)
    |=> (reg_rdata[BIT_FULL:BIT_OVERFLOW] == 4'h0))
    else $error("fifo flags visible in direct mode");

  a_full_follow: assert property (
    reg_rd && (reg_addr == ADDR_FIFO_STATUS) && fifo_modes
    |=> (reg_rdata[BIT_FULL] == $past(fifo_full)) &&
        (reg_rdata[BIT_NOT_EMPTY] == ($past(fifo_count) != '0)))
    else $error("fifo full or not-empty readback wrong");

  a_flush_cmd: assert property (
    (op_state == OP_RX) && reg_wr && (reg_addr == ADDR_FIFO_STATUS) &&
    reg_wdata[BIT_FLUSH]
    |=> buffer_flush ##1 !buffer_flush || (op_state == OP_SLEEP) || reg_wr)
    else $error("flush command not a single pulse");

  a_flush_gated: assert property (
    (op_state == OP_PUP) && reg_wr && (reg_addr == ADDR_FIFO_STATUS)
    |=> !buffer_flush)
    else $error("flush acted in a forbidden state");

  a_sleep_flush: assert property (
    (op_state == OP_SLEEP) |=> buffer_flush && packet_handler_reset)
    else $error("sleep state did not flush and reset");

  a_squelch_zero: assert property (
    reg_rd && (reg_addr == ADDR_SIGNAL_STRENGTH) && (filt_value < squelch_threshold)
    |=> (reg_rdata == 8'h00))
    else $error("signal strength below squelch not zero");

  a_filter_hold: assert property (
    (op_state != OP_RX) |=> $stable(s_q.filt_acc))
    else $error("filter moved outside receive state");

endmodule : rifr_top

// ---- rifr_pkg.sv ----
// constants and state layout for the receiver flag and signal strength block
//------------------------------------------------------------------------------
// Summary of operation
// - sleep timer expiry sets event bit 7
// - receive timer expiry sets event bit 6
// - fsk signal above trigger sets bit 5
// - preamble pass sets event bit 4
// - sync word pass sets event bit 3
// - packet mode node match sets bit 2
// - packet mode checksum pass sets bit 1
// - packet mode packet complete sets bit 0
// - event flag holds until host clear write
// - fifo flags only in buffer or packet mode
// - full flag follows fifo full, bit 6
// - not-empty flag follows nonzero count, bit 5
// - threshold flag when count reaches threshold, bit 4
// - overflow flag follows overflow condition, bit 3
// - writing one to bit 2 flushes fifo
// - flush write only in standby, tune, receive, memory
// - sleep state flushes fifo, resets packet handler
// - signal strength tracks indicator while receiving
// - signal strength is low-pass filtered
// - below squelch threshold reads as zero
//------------------------------------------------------------------------------
package rifr_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_EVENT_CLEAR = 7'h42;
  localparam logic [6:0] ADDR_EVENT_STATUS = 7'h43;
  localparam logic [6:0] ADDR_FIFO_STATUS = 7'h44;
  localparam logic [6:0] ADDR_SIGNAL_STRENGTH = 7'h45;
  // event status bit positions
  localparam int BIT_SLEEP_TMO = 7;
  localparam int BIT_RX_TMO = 6;
  localparam int BIT_SIG_VALID = 5;
  localparam int BIT_PREAMBLE = 4;
  localparam int BIT_SYNCWORD = 3;
  localparam int BIT_NODE = 2;
  localparam int BIT_CHECKSUM = 1;
  localparam int BIT_PKT_DONE = 0;
  // fifo status bit positions
  localparam int BIT_FULL = 6;
  localparam int BIT_NOT_EMPTY = 5;
  localparam int BIT_THRESH = 4;
  localparam int BIT_OVERFLOW = 3;
  localparam int BIT_FLUSH = 2;
  // operating states
  localparam logic [2:0] OP_PUP = 3'h0;
  localparam logic [2:0] OP_SLEEP = 3'h1;
  localparam logic [2:0] OP_STBY = 3'h2;
  localparam logic [2:0] OP_TUNE = 3'h3;
  localparam logic [2:0] OP_RX = 3'h4;
  localparam logic [2:0] OP_EEPROM = 3'h5;
  // data modes
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_BUFFER = 2'h1;
  localparam logic [1:0] MODE_PACKET = 2'h2;
  localparam int FILT_FRAC = 4;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [1:0] RESV_RESET = 2'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [11:0] FILT_RESET = 12'h000;

  typedef struct packed {
    logic [7:0] event_flags;
    logic [1:0] fifo_resv;
    logic [11:0] filt_acc;
    logic [7:0] rdata;
    logic flush;
    logic ph_reset;
  } rifr_state_s;
endpackage : rifr_pkg

// ---- rifr_host.sv ----
// host model driving the register strobe port of the flag block
`timescale 1ns/1ns
module rifr_host
  import rifr_pkg::*;
(
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [rifr_pkg::ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end

  // idle lines show the inverse of the last value so stale data never looks valid
  task automatic idle_bus();
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle_bus

  // reserved low bits of the fifo register are only ever written as zero by callers
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    idle_bus();
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    idle_bus();
    v = reg_rdata;
  endtask : rd
endmodule : rifr_host

// ---- rx_interrupt_flags_signal_strength_value_test.sv ----
// self-checking bench for the receiver flag and signal strength block
`timescale 1ns/1ns
module rx_interrupt_flags_signal_strength_value_test;
  import rifr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr, reg_rd;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, event_flags, signal_strength_value;
  logic buffer_flush, packet_handler_reset;
  logic [2:0] op_state = OP_RX;
  logic [1:0] data_mode = MODE_PACKET;
  logic fsk_sel = 1'b1;
  logic [7:0] en = 8'hFF;
  logic [7:0] ev = 8'h00;
  logic [7:0] raw = 8'h00;
  logic [7:0] squelch = 8'h00;
  logic [5:0] cnt = 6'd0;
  logic full = 1'b0;
  logic ovf = 1'b0;
  logic sl_on = 1'b1;
  logic rx_on = 1'b1;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #20 clock = ~clock;

  rifr_host rifr_host_inst (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // timer run levels are driven so that a stopped timer can be shown to gate its expiry
  rifr_top #(.FIFO_CNT_W(6), .FILT_SHIFT(2)) rifr_top_inst (.clock(clock), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .op_state(op_state), .data_mode(data_mode),
    .fsk_demod_sel(fsk_sel), .sleep_timer_on(sl_on), .sleep_timer_expire(ev[7]),
    .sleep_timeout_irq_enable(en[7]), .rx_timer_on(rx_on), .rx_timer_expire(ev[6]),
    .receive_timeout_irq_enable(en[6]), .signal_valid_irq_enable(en[5]),
    .fsk_trigger_threshold(8'h10), .preamble_pass(ev[4]), .preamble_pass_irq_enable(en[4]),
    .syncword_pass(ev[3]), .syncword_pass_irq_enable(en[3]), .node_match(ev[2]),
    .node_match_irq_enable(en[2]), .checksum_pass(ev[1]), .checksum_pass_irq_enable(en[1]),
    .packet_complete(ev[0]), .packet_complete_irq_enable(en[0]), .fifo_count(cnt),
    .fifo_full(full), .fifo_overflow(ovf), .fifo_threshold(6'd5), .signal_strength_value_raw(raw),
    .squelch_threshold(squelch), .event_flags(event_flags), .buffer_flush(buffer_flush),
    .packet_handler_reset(packet_handler_reset), .signal_strength_value(signal_strength_value));

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  // bit 5 has no pulse input: raw strength just above the trigger stands in for it
  task automatic pulse(input int b);
    step();
    if (b == 5)
      raw = 8'h11;
    else
      ev[b] = 1'b1;
    step();
    ev = 8'h00;
    raw = 8'h00;
  endtask : pulse

  task automatic fifo_case(input logic [1:0] md, input logic [5:0] c, input logic f,
                           input logic o, input logic [7:0] exp);
    logic [7:0] d;
    data_mode = md;
    cnt = c;
    full = f;
    ovf = o;
    rifr_host_inst.rd(ADDR_FIFO_STATUS, d);
    check("fifo status", d, exp);
  endtask : fifo_case

  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic [7:0] m;
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check("reset flags", event_flags, 8'h00);
    rifr_host_inst.rd(7'h46, d);
    check("unmapped read", d, 8'h00);
    $display("test reset done");
    // one cycle of strength 200 from a cleared filter leaves a quarter step
    // valid interrupt masked so the strong sample leaves no flag behind
    en = 8'hDF;
    raw = 8'hC8;
    step();
    raw = 8'h00;
    op_state = OP_STBY;
    check("filtered strength", signal_strength_value, 8'h32);
    rifr_host_inst.rd(ADDR_SIGNAL_STRENGTH, d);
    check("strength read", d, 8'h32);
    squelch = 8'h33;
    step();
    check("squelched", signal_strength_value, 8'h00);
    squelch = 8'h32;
    step();
    check("at squelch", signal_strength_value, 8'h32);
    op_state = OP_RX;
    $display("test strength done");
    for (int b = 0; b < 8; b++)
    begin
      m = 8'h01 << b;
      en = 8'hFF;
      pulse(b);
      check("event set", event_flags, m);
      step();
      check("event held", event_flags, m);
      rifr_host_inst.rd(ADDR_EVENT_STATUS, d);
      check("event read", d, m);
      rifr_host_inst.wr(ADDR_EVENT_CLEAR, ~m);
      check("other clear", event_flags, m);
      op_state = OP_SLEEP;
      rifr_host_inst.wr(ADDR_EVENT_CLEAR, m);
      check("gated clear", event_flags, m);
      op_state = OP_RX;
      rifr_host_inst.wr(ADDR_EVENT_CLEAR, m);
      check("cleared", event_flags, 8'h00);
      en = ~m;
      pulse(b);
      check("masked event", event_flags, 8'h00);
    end
    en = 8'hFF;
    sl_on = 1'b0;
    rx_on = 1'b0;
    pulse(7);
    pulse(6);
    check("stopped timers", event_flags, 8'h00);
    sl_on = 1'b1;
    rx_on = 1'b1;
    // completion and its clear in one cycle: the completion must survive
    fork
      pulse(0);
      rifr_host_inst.wr(ADDR_EVENT_CLEAR, 8'h01);
    join
    check("set over clear", event_flags, 8'h01);
    rifr_host_inst.wr(ADDR_EVENT_CLEAR, 8'h01);
    check("late clear", event_flags, 8'h00);
    data_mode = MODE_BUFFER;
    fsk_sel = 1'b0;
    for (int b = 0; b < 4; b++)
      pulse(b == 3 ? 5 : b);
    check("mode gated events", event_flags, 8'h00);
    fsk_sel = 1'b1;
    raw = 8'h10;
    step();
    raw = 8'h00;
    step();
    check("equal trigger", event_flags, 8'h00);
    $display("test events done");
    fifo_case(MODE_BUFFER, 6'd5, 1'b0, 1'b0, 8'h30);
    fifo_case(MODE_BUFFER, 6'd4, 1'b0, 1'b0, 8'h20);
    fifo_case(MODE_BUFFER, 6'd0, 1'b0, 1'b0, 8'h00);
    fifo_case(MODE_PACKET, 6'd63, 1'b1, 1'b1, 8'h78);
    fifo_case(MODE_PACKET, 6'd63, 1'b0, 1'b0, 8'h30);
    fifo_case(MODE_DIRECT, 6'd63, 1'b1, 1'b1, 8'h00);
    $display("test fifo flags done");
    for (int s = 2; s < 6; s++)
    begin
      op_state = 3'(s);
      rifr_host_inst.wr(ADDR_FIFO_STATUS, 8'h04);
      check("flush", {7'h00, buffer_flush}, 8'h01);
      step();
      check("flush pulse", {7'h00, buffer_flush}, 8'h00);
    end
    rifr_host_inst.wr(ADDR_FIFO_STATUS, 8'h00);
    check("no flush", {7'h00, buffer_flush}, 8'h00);
    op_state = OP_PUP;
    rifr_host_inst.wr(ADDR_FIFO_STATUS, 8'h04);
    check("refused flush", {7'h00, buffer_flush}, 8'h00);
    op_state = OP_SLEEP;
    step();
    step();
    check("sleep flush", {6'h00, buffer_flush, packet_handler_reset}, 8'h03);
    op_state = OP_RX;
    step();
    step();
    check("sleep left", {6'h00, buffer_flush, packet_handler_reset}, 8'h00);
    $display("test flush done");
    print_verdict();
  end
endmodule : rx_interrupt_flags_signal_strength_value_test
